// File: fmt_conv_pkg.sv
// shared constants, types and register map of the float format converter
package fmt_conv_pkg;

    // ------------------------------------------------------------
    // word layouts
    // ------------------------------------------------------------
    localparam int WORD_W  = 32;
    localparam int EXP_W   = 8;
    localparam int FRAC_W  = 23;

    typedef struct packed {
        logic [EXP_W-1:0]  exp;
        logic              sign;
        logic [FRAC_W-1:0] frac;
    } native_word_t;

    typedef struct packed {
        logic              sign;
        logic [EXP_W-1:0]  exp;
        logic [FRAC_W-1:0] frac;
    } ieee_word_t;

    typedef struct packed {
        logic c6;
        logic c7;
        logic c8;
        logic c9;
        logic c10;
        logic c11;
        logic c12;
    } native_case_t;

    // ------------------------------------------------------------
    // numeric constants
    // ------------------------------------------------------------
    localparam logic [EXP_W-1:0]  EXP_ZERO_NAT  = 8'h80;
    localparam logic [EXP_W-1:0]  EXP_MAX_NAT   = 8'h7f;
    localparam logic [6:0]        EXP_LOW_TOP   = 7'h40;
    localparam logic [EXP_W-1:0]  BIAS_POS      = 8'h7f;
    localparam logic [EXP_W-1:0]  BIAS_NEG_PWR  = 8'h80;
    localparam logic [EXP_W-1:0]  BIAS_TO_NAT   = 8'h81;
    localparam logic [EXP_W-1:0]  EXP_ALL_ONES  = 8'hff;
    localparam logic [EXP_W-1:0]  EXP_ALL_ZERO  = 8'h00;
    localparam logic [EXP_W-1:0]  EXP_DEN_NAT   = 8'h81;
    localparam logic [FRAC_W-1:0] FRAC_HIDDEN   = 23'h400000;
    localparam logic [FRAC_W-1:0] FRAC_ZERO     = 23'h000000;
    localparam logic [FRAC_W-1:0] FRAC_ONE      = 23'h000001;
    localparam logic [FRAC_W-1:0] FRAC_ALL_ONES = 23'h7fffff;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_PS    = 20000;
    localparam int NAN_PULSE_PS     = 30000;
    localparam int NAN_PULSE_CYCLES = (NAN_PULSE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // ------------------------------------------------------------
    // register map (byte addresses) and fields
    // ------------------------------------------------------------
    localparam int               REG_AW       = 8;
    localparam logic [REG_AW-1:0] ADDR_CTRL    = 8'h00;
    localparam logic [REG_AW-1:0] ADDR_STATUS  = 8'h04;
    localparam logic [REG_AW-1:0] ADDR_NAN_CNT = 8'h08;
    localparam logic [REG_AW-1:0] ADDR_LAST_IN = 8'h0c;
    localparam logic [REG_AW-1:0] ADDR_LAST_OUT = 8'h10;

    localparam int CTRL_PIPE_BIT   = 0;
    localparam int CTRL_ENABLE_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h2;

    localparam int STAT_BUSY_BIT    = 0;
    localparam int STAT_OVERLAP_BIT = 1;
    localparam int STAT_DIR_BIT     = 2;
    localparam int STAT_CASE_LSB    = 8;
    localparam int NAN_CNT_W        = 16;

    localparam logic [WORD_W-1:0] WORD_ZERO = 32'h00000000;

endpackage : fmt_conv_pkg

// File: fmt_conv_top.sv
// float format converter between the processor bus and ieee memory
// Function
// - derive low-range (80h/81h), max (7Fh) and fraction-zero flags from native word
// - case 6 when not low range and sign clear
// - case 7 when low range, exponent bit 24 set, sign clear
// - exponent 80h is zero (case 8) whatever sign and fraction hold
// - negative 80h word with nonzero fraction raises cases 8 and 9 together
// - case 9 when low range, sign set, fraction nonzero
// - case 10 when not exponent 80h, not max, sign set, fraction zero
// - case 11 when not low range, sign set, fraction nonzero
// - case 12 when max exponent, sign set, fraction zero
// - ieee sign copies native sign except zero, which gives sign 0
// - exponent adds 7Fh (6,11), 00 (7,8,9), adds 80h (10), FFh (12)
// - fraction per case: copy, halved plus 400000h, negated forms, or zero
// - denormal results shift mantissa right one place, losing lowest bit
// - values without exact match give the nearest representable value; ieee denormals below the native floor become zero instead
// - ieee nan passes its payload through unconverted
// - nan sign and exponent move into native sign and exponent positions
// - a nan presented for conversion raises the nan interrupt
// - infinities become the largest positive or most negative native value
// - processor read converts ieee to native, write converts native to ieee
// - nan interrupt is a short pulse for edge-triggered inputs
// - flow-through mode takes two cycles and inserts one wait state
// - pipelined mode converts per cycle, outputting the previous value
//
// Added by the designer: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
module fmt_conv_top
    import fmt_conv_pkg::*;
#(
    parameter int NAN_CYCLES = NAN_PULSE_CYCLES
)(
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // processor side
    input  wire logic              dsp_strobe_i,
    input  wire logic              transfer_direction_i,
    input  wire logic [WORD_W-1:0] dsp_data_i,
    output logic [WORD_W-1:0]      dsp_data_o,
    output logic                   dsp_ready_o,
    output logic                   nan_interrupt_o,
    // memory side
    input  wire logic [WORD_W-1:0] mem_data_i,
    output logic [WORD_W-1:0]      mem_data_o,
    output logic                   mem_we_o,
    // wishbone slave
    input  wire logic              cyc_i,
    input  wire logic              stb_i,
    input  wire logic              we_i,
    input  wire logic [REG_AW-1:0] adr_i,
    input  wire logic [3:0]        sel_i,
    input  wire logic [WORD_W-1:0] dat_i,
    output logic [WORD_W-1:0]      dat_o,
    output logic                   ack_o
);

    // ------------------------------------------------------------
    // native word classification
    // ------------------------------------------------------------
    function automatic native_case_t classify(input native_word_t w);
        logic low_range;
        logic max_exp;
        logic fz;
        native_case_t c;
        low_range = (w.exp[EXP_W-1:1] == EXP_LOW_TOP);
        max_exp   = (w.exp == EXP_MAX_NAT);
        fz        = (w.frac == FRAC_ZERO);
        c.c6  = !low_range && !w.sign;
        c.c7  = low_range && w.exp[0] && !w.sign;
        c.c8  = low_range && !w.exp[0];
        c.c9  = low_range && w.sign && !fz;
        c.c10 = !(low_range && !w.exp[0]) && !max_exp && w.sign && fz;
        c.c11 = !low_range && w.sign && !fz;
        c.c12 = max_exp && w.sign && fz;
        return c;
    endfunction : classify

    // ------------------------------------------------------------
    // native to ieee translation
    // ------------------------------------------------------------
    function automatic ieee_word_t native_to_ieee(input native_word_t w);
        native_case_t c;
        logic [FRAC_W-1:0] neg;
        ieee_word_t r;
        c   = classify(w);
        neg = ~w.frac + FRAC_ONE;
        r.sign = c.c8 ? 1'b0 : w.sign;
        r.exp  = EXP_ALL_ZERO;
        r.frac = FRAC_ZERO;
        if (c.c8) begin
            // zero wins over the overlapping negative denormal case
            r.exp  = EXP_ALL_ZERO;
            r.frac = FRAC_ZERO;
        end else if (c.c6) begin
            r.exp  = w.exp + BIAS_POS;
            r.frac = w.frac;
        end else if (c.c7) begin
            r.exp  = EXP_ALL_ZERO;
            r.frac = {1'b0, w.frac[FRAC_W-1:1]} + FRAC_HIDDEN;
        end else if (c.c9) begin
            r.exp  = EXP_ALL_ZERO;
            r.frac = {1'b0, neg[FRAC_W-1:1]} + FRAC_HIDDEN;
        end else if (c.c10) begin
            r.exp  = w.exp + BIAS_NEG_PWR;
            r.frac = FRAC_ZERO;
        end else if (c.c11) begin
            r.exp  = w.exp + BIAS_POS;
            r.frac = neg;
        end else if (c.c12) begin
            // -2^128 saturates to negative infinity
            r.exp  = EXP_ALL_ONES;
            r.frac = FRAC_ZERO;
        end
        return r;
    endfunction : native_to_ieee

    // ------------------------------------------------------------
    // control register
    // ------------------------------------------------------------
    logic [1:0]  ctrl;
    logic [1:0]  next_ctrl;
    logic        pipeline_select;
    logic        conv_enable;

    assign pipeline_select = ctrl[CTRL_PIPE_BIT];
    assign conv_enable     = ctrl[CTRL_ENABLE_BIT];

    // ------------------------------------------------------------
    // transfer sequencing
    // ------------------------------------------------------------
    typedef enum logic [1:0] {ST_IDLE, ST_CONVERT, ST_DONE} xfer_state_t;

    xfer_state_t       state;
    xfer_state_t       next_state;
    logic [WORD_W-1:0] stage_word;
    logic [WORD_W-1:0] next_stage_word;
    logic              stage_dir;
    logic              next_stage_dir;
    logic [WORD_W-1:0] next_dsp_data;
    logic [WORD_W-1:0] next_mem_data;
    logic              next_dsp_ready;
    logic              next_mem_we;
    logic [WORD_W-1:0] last_in;
    logic [WORD_W-1:0] next_last_in;
    logic [WORD_W-1:0] last_out;
    logic [WORD_W-1:0] next_last_out;
    native_case_t      last_case;
    native_case_t      next_last_case;
    logic              convert_now;
    logic              nan_seen;
    logic              take;

    native_word_t      stage_native;
    native_word_t      from_ieee;
    ieee_word_t        to_ieee;
    logic              stage_is_nan;

    assign stage_native = native_word_t'(stage_word);
    assign to_ieee      = native_to_ieee(stage_native);

    ieee_to_native_conv u_ieee_to_native (
        .ieee_i   (ieee_word_t'(stage_word)),
        .native_o (from_ieee),
        .is_nan_o (stage_is_nan)
    );

    assign take = dsp_strobe_i && conv_enable;

    always_comb begin
        next_state      = state;
        next_stage_word = stage_word;
        next_stage_dir  = stage_dir;
        next_dsp_data   = dsp_data_o;
        next_mem_data   = mem_data_o;
        next_dsp_ready  = 1'b0;
        next_mem_we     = 1'b0;
        next_last_in    = last_in;
        next_last_out   = last_out;
        next_last_case  = last_case;
        convert_now     = 1'b0;
        unique case (state)
            ST_IDLE: begin
                if (take) begin
                    // read fetches ieee from memory, write takes native from processor
                    next_stage_word = transfer_direction_i ? mem_data_i : dsp_data_i;
                    next_stage_dir  = transfer_direction_i;
                    next_last_in    = transfer_direction_i ? mem_data_i : dsp_data_i;
                    if (pipeline_select) begin
                        // previous stage is emitted while the new word loads
                        convert_now    = 1'b1;
                        next_dsp_ready = 1'b1;
                        next_state     = ST_DONE;
                    end else begin
                        next_state = ST_CONVERT;
                    end
                end
            end
            ST_CONVERT: begin
                convert_now    = 1'b1;
                next_dsp_ready = 1'b1;
                next_state     = ST_DONE;
            end
            ST_DONE: begin
                next_state = ST_IDLE;
            end
        endcase
        if (convert_now) begin
            if (stage_dir) begin
                next_dsp_data = WORD_W'(from_ieee);
                next_last_out = WORD_W'(from_ieee);
            end else begin
                next_mem_data  = WORD_W'(to_ieee);
                next_mem_we    = 1'b1;
                next_last_out  = WORD_W'(to_ieee);
                next_last_case = classify(stage_native);
            end
        end
    end

    assign nan_seen = convert_now && stage_dir && stage_is_nan;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state      <= ST_IDLE;
            stage_word <= WORD_ZERO;
            stage_dir  <= 1'b0;
            dsp_data_o <= WORD_ZERO;
            mem_data_o <= WORD_ZERO;
            dsp_ready_o <= 1'b0;
            mem_we_o   <= 1'b0;
            last_in    <= WORD_ZERO;
            last_out   <= WORD_ZERO;
            last_case  <= '0;
        end else begin
            state      <= next_state;
            stage_word <= next_stage_word;
            stage_dir  <= next_stage_dir;
            dsp_data_o <= next_dsp_data;
            mem_data_o <= next_mem_data;
            dsp_ready_o <= next_dsp_ready;
            mem_we_o   <= next_mem_we;
            last_in    <= next_last_in;
            last_out   <= next_last_out;
            last_case  <= next_last_case;
        end
    end

    // ------------------------------------------------------------
    // nan interrupt pulse
    // ------------------------------------------------------------
    localparam int NAN_CNT_BITS = $clog2(NAN_CYCLES + 1);

    logic [NAN_CNT_BITS-1:0] nan_left;
    logic [NAN_CNT_BITS-1:0] next_nan_left;
    logic                    next_nan_irq;

    always_comb begin
        next_nan_left = nan_left;
        if (nan_seen) begin
            next_nan_left = NAN_CNT_BITS'(NAN_CYCLES);
        end else if (nan_left != '0) begin
            next_nan_left = nan_left - 1'b1;
        end
        next_nan_irq = (next_nan_left != '0);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            nan_left        <= '0;
            nan_interrupt_o <= 1'b0;
        end else begin
            nan_left        <= next_nan_left;
            nan_interrupt_o <= next_nan_irq;
        end
    end

    // ------------------------------------------------------------
    // wishbone register slave
    // ------------------------------------------------------------
    logic [NAN_CNT_W-1:0] nan_count;
    logic [NAN_CNT_W-1:0] next_nan_count;
    logic [WORD_W-1:0]    next_dat;
    logic                 next_ack;
    logic                 wb_req;
    logic                 wb_write;

    assign wb_req   = cyc_i && stb_i && !ack_o;
    assign wb_write = wb_req && we_i;

    function automatic logic [WORD_W-1:0] status_word(input xfer_state_t s,
                                                     input native_case_t c,
                                                     input logic d);
        logic [WORD_W-1:0] v;
        v = WORD_ZERO;
        v[STAT_BUSY_BIT]    = (s != ST_IDLE);
        v[STAT_OVERLAP_BIT] = c.c8 && c.c9;
        v[STAT_DIR_BIT]     = d;
        v[STAT_CASE_LSB +: $bits(native_case_t)] = c;
        return v;
    endfunction : status_word

    always_comb begin
        next_ctrl      = ctrl;
        next_nan_count = nan_count;
        next_dat       = WORD_ZERO;
        next_ack       = wb_req;
        if (wb_write && adr_i == ADDR_CTRL && sel_i[0]) begin
            next_ctrl = dat_i[1:0];
        end
        // a write clears the counter but a nan in the same cycle still counts
        if (wb_write && adr_i == ADDR_NAN_CNT && sel_i[0]) begin
            next_nan_count = '0;
        end
        if (nan_seen) begin
            next_nan_count = next_nan_count + 1'b1;
        end
        if (wb_req && !we_i) begin
            unique case (adr_i)
                ADDR_CTRL:     next_dat = {30'h00000000, ctrl};
                ADDR_STATUS:   next_dat = status_word(state, last_case, stage_dir);
                ADDR_NAN_CNT:  next_dat = {16'h0000, nan_count};
                ADDR_LAST_IN:  next_dat = last_in;
                ADDR_LAST_OUT: next_dat = last_out;
                default:       next_dat = WORD_ZERO;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl      <= CTRL_RESET;
            nan_count <= '0;
            dat_o     <= WORD_ZERO;
            ack_o     <= 1'b0;
        end else begin
            ctrl      <= next_ctrl;
            nan_count <= next_nan_count;
            dat_o     <= next_dat;
            ack_o     <= next_ack;
        end
    end

endmodule : fmt_conv_top

// File: fmt_conv_top_asserts.sv
// concurrent checks on the converter top ports
`timescale 1ns/1ps
module fmt_conv_checker
    import fmt_conv_pkg::*;
#(
    parameter int NAN_CYCLES = NAN_PULSE_CYCLES
)(
    input wire logic              clk_i,
    input wire logic              rst_i,
    input wire logic              dsp_strobe_i,
    input wire logic [WORD_W-1:0] dsp_data_o,
    input wire logic              dsp_ready_o,
    input wire logic              nan_interrupt_o,
    input wire logic [WORD_W-1:0] mem_data_o,
    input wire logic              mem_we_o,
    input wire logic              cyc_i,
    input wire logic              stb_i,
    input wire logic              we_i,
    input wire logic [REG_AW-1:0] adr_i,
    input wire logic [3:0]        sel_i,
    input wire logic [WORD_W-1:0] dat_i,
    input wire logic [WORD_W-1:0] dat_o,
    input wire logic              ack_o
);
    logic [7:0] cnt;
    logic [7:0] next_cnt;
    logic       pipe;
    logic       en;
    logic       next_pipe;
    logic       next_en;
    logic       ctrl_wr;

    // ----------------------------------------
    // shadow of mode bits, nan pulse length
    // ----------------------------------------
    always_comb begin
        ctrl_wr   = cyc_i && stb_i && we_i && ack_o && sel_i[0] && adr_i == ADDR_CTRL;
        next_cnt  = nan_interrupt_o ? cnt + 8'h01 : 8'h00;
        next_pipe = ctrl_wr ? dat_i[CTRL_PIPE_BIT] : pipe;
        next_en   = ctrl_wr ? dat_i[CTRL_ENABLE_BIT] : en;
    end

    always_ff @(posedge clk_i) begin
        cnt  <= rst_i ? 8'h00 : next_cnt;
        pipe <= rst_i ? 1'b0 : next_pipe;
        en   <= rst_i ? 1'b1 : next_en;
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    a_flow_wait_state: assert property ($rose(dsp_strobe_i) && en && !pipe |-> ##1 !dsp_ready_o ##1 dsp_ready_o)
        else $error("flow-through ready not on second cycle");
    a_pipe_single: assert property ($rose(dsp_strobe_i) && en && pipe |=> dsp_ready_o)
        else $error("pipelined ready not on next cycle");
    a_ready_pulse: assert property (dsp_ready_o |=> !dsp_ready_o)
        else $error("ready longer than one cycle");
    a_nan_width: assert property ($fell(nan_interrupt_o) |-> cnt == NAN_CYCLES)
        else $error("nan pulse too short");
    a_nan_bound: assert property (nan_interrupt_o |-> cnt < NAN_CYCLES)
        else $error("nan pulse too long");
    a_nan_on_ready: assert property ($rose(nan_interrupt_o) |-> dsp_ready_o)
        else $error("nan pulse without a conversion");
    a_write_ready: assert property (mem_we_o |-> dsp_ready_o)
        else $error("memory write without transfer end");
    a_mem_hold: assert property ($changed(mem_data_o) |-> mem_we_o)
        else $error("memory word changed without write");
    a_read_hold: assert property ($changed(dsp_data_o) |-> dsp_ready_o)
        else $error("read word changed without transfer end");
    a_ack_next: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("bus ack missing");
    a_dat_idle: assert property (!ack_o |-> dat_o == WORD_ZERO)
        else $error("bus data not zero while idle");

    c_nan: cover property ($fell(nan_interrupt_o));
    c_pipe: cover property ($rose(dsp_strobe_i) && pipe);
    c_ctrl: cover property (ctrl_wr);
endmodule : fmt_conv_checker

bind fmt_conv_top fmt_conv_checker #(.NAN_CYCLES(NAN_CYCLES)) u_chk (
    .clk_i(clk_i), .rst_i(rst_i), .dsp_strobe_i(dsp_strobe_i), .dsp_data_o(dsp_data_o),
    .dsp_ready_o(dsp_ready_o), .nan_interrupt_o(nan_interrupt_o), .mem_data_o(mem_data_o),
    .mem_we_o(mem_we_o), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o));

// File: fmt_conv_top_bench.sv
// self-checking bench for the float format converter
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin check_count++; if ((gt) !== (ex)) begin mismatches++; \
    $display("[FAIL] %s expected %h seen %h", nm, ex, gt); end end
module fmt_conv_top_bench
    import fmt_conv_pkg::*;
();
    logic clk_i = 0, rst_i = 1, dsp_strobe_i = 0, transfer_direction_i = 0;
    logic cyc_i = 0, stb_i = 0, we_i = 0, load = 0;
    logic [REG_AW-1:0] adr_i = '0;
    logic [3:0]        sel_i = '0;
    logic [WORD_W-1:0] dsp_data_i = '0, dat_i = '0, ldat = '0, mem_data_i, dsp_data_o, mem_data_o, dat_o, q;
    logic              dsp_ready_o, nan_interrupt_o, mem_we_o, ack_o, f;
    int                mismatches = 0, check_count = 0, i;

    fmt_conv_top dut (.clk_i(clk_i), .rst_i(rst_i), .dsp_strobe_i(dsp_strobe_i),
        .transfer_direction_i(transfer_direction_i), .dsp_data_i(dsp_data_i), .dsp_data_o(dsp_data_o),
        .dsp_ready_o(dsp_ready_o), .nan_interrupt_o(nan_interrupt_o), .mem_data_i(mem_data_i),
        .mem_data_o(mem_data_o), .mem_we_o(mem_we_o), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o));
    fmt_mem_model mem (.clk_i(clk_i), .rst_i(rst_i), .we_i(mem_we_o), .wdata_i(mem_data_o),
        .load_i(load), .load_data_i(ldat), .rdata_o(mem_data_i));

    initial begin
        forever #10 clk_i = ~clk_i;
    end

    task automatic wb(input logic w, input logic [REG_AW-1:0] a, input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a; dat_i <= d; sel_i <= 4'hf;
        do begin @(posedge clk_i); n++; end while (ack_o !== 1'b1 && n < 50);
        if (n >= 50) mismatches++;
        r = dat_o;
        cyc_i <= 1'b0; stb_i <= 1'b0;
    endtask : wb

    task automatic xfer(input logic d, input logic [31:0] w, output logic [31:0] r, output logic fl);
        int n;
        n = 0;
        @(posedge clk_i);
        dsp_strobe_i <= 1'b1; transfer_direction_i <= d; dsp_data_i <= w;
        do begin @(posedge clk_i); n++; end while (dsp_ready_o !== 1'b1 && n < 50);
        if (n >= 50) mismatches++;
        r  = d ? dsp_data_o : mem_data_o;
        fl = d ? nan_interrupt_o : mem_we_o;
        dsp_strobe_i <= 1'b0;
    endtask : xfer

    task automatic wr_case(input logic [31:0] n, input logic [31:0] e);
        xfer(1'b0, n, q, f);
        `CHK("mem_data_o", e, q)
        `CHK("mem_we_o", 1'b1, f)
    endtask : wr_case

    task automatic rd_case(input logic [31:0] v, input logic [31:0] e, input logic nan_interrupt);
        @(posedge clk_i);
        load <= 1'b1; ldat <= v;
        @(posedge clk_i);
        load <= 1'b0;
        xfer(1'b1, v, q, f);
        `CHK("dsp_data_o", e, q)
        `CHK("nan_interrupt_o", nan_interrupt, f)
    endtask : rd_case

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : print_verdict

    // about 120 cycles of tests, limit well above
    initial begin
        #200us;
        mismatches++;
        print_verdict();
    end

    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, ADDR_CTRL, '0, q);
        `CHK("ctrl", WORD_W'(CTRL_RESET), q)
        wb(1'b1, 8'hfc, 32'hffffffff, q);
        wb(1'b0, 8'hfc, '0, q);
        `CHK("unmapped", WORD_ZERO, q)
        $display("test registers done");
        wr_case(32'h00000000, 32'h3f800000);
        wr_case(32'h7f7fffff, 32'h7f7fffff);
        wr_case(32'h81000002, 32'h00400001);
        wr_case(32'h81000001, 32'h00400000);
        wr_case(32'h80000000, 32'h00000000);
        wr_case(32'h80400123, 32'h00000000);
        wr_case(32'h80800005, 32'h00000000);
        wb(1'b0, ADDR_STATUS, '0, q);
        `CHK("status", 32'h00001802, q)
        wb(1'b0, ADDR_LAST_IN, '0, q);
        `CHK("last in", 32'h80800005, q)
        wr_case(32'h81800002, 32'h807fffff);
        wr_case(32'h81800000, 32'h80800000);
        wr_case(32'h00800000, 32'hc0000000);
        wr_case(32'h00c00000, 32'hbfc00000);
        wr_case(32'h7f800000, 32'hff800000);
        $display("test native to ieee done");
        rd_case(32'h3f800000, 32'h00000000, 1'b0);
        rd_case(32'h7fc00001, 32'hff400001, 1'b1);
        rd_case(32'h7f800000, 32'h7f7fffff, 1'b0);
        rd_case(32'hff800000, 32'h7f800000, 1'b0);
        wb(1'b0, ADDR_NAN_CNT, '0, q);
        `CHK("nan count", 32'h00000001, q)
        $display("test ieee to native done");
        wb(1'b1, ADDR_CTRL, 32'h3, q);
        xfer(1'b0, 32'h00000000, q, f);
        xfer(1'b0, 32'h81800000, q, f);
        `CHK("pipe first", 32'h3f800000, q)
        xfer(1'b0, 32'h00000000, q, f);
        `CHK("pipe flush", 32'h80800000, q)
        wb(1'b0, ADDR_LAST_OUT, '0, q);
        `CHK("last out", 32'h80800000, q)
        $display("test pipeline done");
        wb(1'b1, ADDR_CTRL, 32'h0, q);
        @(posedge clk_i);
        dsp_strobe_i <= 1'b1;
        for (i = 0; i < 6; i++) begin
            @(posedge clk_i);
            `CHK("ready while off", 1'b0, dsp_ready_o)
        end
        dsp_strobe_i <= 1'b0;
        wb(1'b1, ADDR_CTRL, 32'h2, q);
        $display("test disabled done");
        print_verdict();
    end
endmodule : fmt_conv_top_bench

// File: fmt_mem_model.sv
// ieee memory model on the far side of the converter
`timescale 1ns/1ps
module fmt_mem_model
    import fmt_conv_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              we_i,
    input  wire logic [WORD_W-1:0] wdata_i,
    input  wire logic              load_i,
    input  wire logic [WORD_W-1:0] load_data_i,
    output logic [WORD_W-1:0]      rdata_o
);
    logic [WORD_W-1:0] word;
    logic [WORD_W-1:0] next_word;

    // write strobes store converted words, reads return the stored word
    always_comb next_word = we_i ? wdata_i : (load_i ? load_data_i : word);

    always_ff @(posedge clk_i) begin
        word <= rst_i ? WORD_ZERO : next_word;
    end

    assign rdata_o = word;
endmodule : fmt_mem_model

// File: ieee_to_native_conv.sv
// combinational translation of an ieee single word into the native word
`timescale 1ns/1ps
module ieee_to_native_conv
    import fmt_conv_pkg::*;
(
    input  wire ieee_word_t   ieee_i,
    output native_word_t      native_o,
    output logic              is_nan_o
);
    logic exp_ones;
    logic exp_zero;
    logic frac_zero;
    logic [FRAC_W-1:0] shifted;

    always_comb begin
        exp_ones  = (ieee_i.exp == EXP_ALL_ONES);
        exp_zero  = (ieee_i.exp == EXP_ALL_ZERO);
        frac_zero = (ieee_i.frac == FRAC_ZERO);
        shifted   = {ieee_i.frac[FRAC_W-2:0], 1'b0};
        is_nan_o  = exp_ones && !frac_zero;
        native_o  = '{exp: EXP_ZERO_NAT, sign: 1'b0, frac: FRAC_ZERO};
        if (exp_ones && !frac_zero) begin
            // payload kept, sign and exponent moved into native positions
            native_o = '{exp: ieee_i.exp, sign: ieee_i.sign, frac: ieee_i.frac};
        end else if (exp_ones) begin
            // infinities saturate to the extreme native values
            native_o.exp  = EXP_MAX_NAT;
            native_o.sign = ieee_i.sign;
            native_o.frac = ieee_i.sign ? FRAC_ZERO : FRAC_ALL_ONES;
        end else if (!exp_zero) begin
            native_o.sign = ieee_i.sign;
            if (!ieee_i.sign) begin
                native_o.exp  = ieee_i.exp + BIAS_TO_NAT;
                native_o.frac = ieee_i.frac;
            end else if (frac_zero) begin
                native_o.exp  = ieee_i.exp + BIAS_NEG_PWR;
                native_o.frac = FRAC_ZERO;
            end else begin
                native_o.exp  = ieee_i.exp + BIAS_TO_NAT;
                native_o.frac = ~ieee_i.frac + FRAC_ONE;
            end
        end else if (ieee_i.frac[FRAC_W-1]) begin
            // denormals at or above the native floor; smaller ones become zero
            native_o.exp  = EXP_DEN_NAT;
            native_o.sign = ieee_i.sign;
            native_o.frac = ieee_i.sign ? (~shifted + FRAC_ONE) : shifted;
        end
    end

endmodule : ieee_to_native_conv
